// ==== rtl/sink_off_pkg.sv ====
// Constants shared by the sink off-time timer block.
// Assumes a 100 MHz system clock and an 8-bit register write/read port.
package sink_off_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned TICK_MS         = 100;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam logic [7:0]  ADDR_SINK7_OFF  = 8'h1f;
  localparam logic [7:0]  ADDR_SINK8_OFF  = 8'h20;
  localparam logic [7:0]  ADDR_SINK9_OFF  = 8'h21;
  localparam logic [7:0]  ADDR_FADE       = 8'h22;
  localparam int unsigned CODE_MSB        = 6;
  localparam int unsigned FADE_OUT_LSB    = 4;
  localparam logic [6:0]  CODE_DISABLED   = 7'h00;
  localparam logic [6:0]  CODE_HOLD_OFF   = 7'h7f;
  localparam logic [6:0]  CODE_ZERO_SEC   = 7'h01;
  localparam logic [7:0]  OFF_TIME_RESET  = 8'h00;
  localparam logic [3:0]  FADE_OUT_OFF    = 4'h0;

  typedef enum logic [2:0] {
    ST_ON   = 3'b001,
    ST_OFF  = 3'b010,
    ST_HOLD = 3'b100
  } phase_t;
endpackage : sink_off_pkg

// ==== rtl/sink_off_channel.sv ====
// One sink's off phase sequencer.
// Assumes on_done pulses once when the on-time timer ends an on phase.
`timescale 1ns/100ps
module sink_off_channel
  import sink_off_pkg::*;
(
  input  wire logic       clk,      // System clock
  input  wire logic       rst_n,    // Synchronised reset
  input  wire logic       tick,     // 0.1 s enable pulse
  input  wire logic       enable,   // Sink enable
  input  wire logic [6:0] off_code, // Off-time code
  input  wire logic       on_done,  // On phase ended
  output logic            conduct,  // Sink current on
  output logic            off_end   // Pulse: off phase over
);
  phase_t     phase;
  phase_t     next_phase;
  logic [6:0] count;
  logic [6:0] next_count;
  logic       next_off_end;

  always_comb begin
    next_phase   = phase;
    next_count   = count;
    next_off_end = 1'b0;
    case (phase)
      ST_ON: begin
        if (enable && on_done && off_code != CODE_DISABLED) begin
          next_count = 7'h00;
          next_phase = (off_code == CODE_HOLD_OFF) ? ST_HOLD : ST_OFF;
        end
      end
      ST_OFF: begin
        if (!enable || off_code == CODE_DISABLED) begin
          next_phase = ST_ON;
        end else if (count + 7'h01 >= off_code) begin
          next_phase   = ST_ON;
          next_off_end = 1'b1;
        end else if (tick) begin
          next_count = count + 7'h01;
        end
      end
      ST_HOLD: begin
        if (!enable || off_code != CODE_HOLD_OFF) next_phase = ST_ON;
      end
      default: next_phase = ST_ON;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase   <= ST_ON;
      count   <= 7'h00;
      conduct <= 1'b0;
      off_end <= 1'b0;
    end else begin
      phase   <= next_phase;
      count   <= next_count;
      conduct <= enable && (next_phase == ST_ON);
      off_end <= next_off_end;
    end
  end

  AST_DISABLED_CONDUCTS: assert property (@(posedge clk) disable iff (!rst_n)
    (enable && off_code == CODE_DISABLED) [*2] |=> conduct)
    else $error("sink dark while off time disabled");
  AST_HOLD_STAYS_DARK: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == ST_HOLD && enable && off_code == CODE_HOLD_OFF) |=> !conduct)
    else $error("held-off sink conducted");
  AST_OFF_ENTERED: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == ST_ON && enable && on_done && off_code > CODE_ZERO_SEC
     && off_code != CODE_HOLD_OFF) |=> phase == ST_OFF ##0 !conduct)
    else $error("off phase not entered");
  AST_COUNT_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(phase == ST_OFF)) |-> count == 7'h00)
    else $error("off counter did not restart");
endmodule : sink_off_channel

// ==== rtl/sink_blink_off_timer.sv ====
// Off-time timers for independent sinks 7, 8 and 9 with their byte registers.
// Assumes a byte register port synchronous to clk and on-time pulses from outside.
// Functional notes
// - Each off-time register keeps the code in bits 6..0 and bit 7 reserved, reading zero.
// - A zero code keeps the sink conducting for as long as it is enabled.
// - Codes 1 to 126 turn the sink off for the off period, then back on under on-time control.
// - Code 1 gives 0.0 s, rising 0.1 s per code step up to 12.5 s at code 126.
// - Code 127 holds the sink off indefinitely once it turns off.
// - The off-time registers of sinks 7, 8 and 9 sit at 0x1f, 0x20 and 0x21.
// - The shared fade-out time field is bits 7..4 of the fade register; zero means instant off.
`timescale 1ns/100ps
module sink_blink_off_timer
  import sink_off_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES // Cycles per 0.1 s tick
) (
  input  wire logic       clk,          // System clock, 100 MHz
  input  wire logic       arst_n,       // Asynchronous reset, active low
  input  wire logic       reg_wr,       // Register write strobe
  input  wire logic       reg_rd,       // Register read strobe
  input  wire logic [7:0] reg_addr,     // Register address
  input  wire logic [7:0] reg_wdata,    // Register write data
  output logic      [7:0] reg_rdata,    // Registered read data
  input  wire logic [2:0] sink_enable,  // Enables of sinks 9..7
  input  wire logic [2:0] sink_on_done, // On phase end pulses, sinks 9..7
  output logic      [2:0] sink_current, // Current on, sinks 9..7
  output logic      [2:0] sink_off_end, // Off phase end pulses, sinks 9..7
  output logic            fade_active,  // Nonzero fade-out time
  output logic            zero_warn     // 0.0 s off code with no fade-out
);
  // A divide of one would fire the tick every cycle and break the tick spacing
  if (TICK_DIV < 2) begin : g_bad_div
    $error("TICK_DIV must be at least 2");
  end

  logic        rst_meta;
  logic        rst_n;
  logic [6:0]  sink7_off_code;
  logic [6:0]  sink8_off_code;
  logic [6:0]  sink9_off_code;
  logic [3:0]  sink_fade_out_time;
  logic [6:0]  next_sink7_off_code;
  logic [6:0]  next_sink8_off_code;
  logic [6:0]  next_sink9_off_code;
  logic [3:0]  next_sink_fade_out_time;
  logic [7:0]  next_reg_rdata;
  logic [31:0] div_count;
  logic [31:0] next_div_count;
  logic        tick;
  logic        next_tick;
  logic [20:0] codes;
  logic [2:0]  conduct;
  logic [2:0]  off_end;
  logic        next_zero_warn;

  // Reset enters asynchronously, is released through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  always_comb begin
    next_sink7_off_code     = sink7_off_code;
    next_sink8_off_code     = sink8_off_code;
    next_sink9_off_code     = sink9_off_code;
    next_sink_fade_out_time = sink_fade_out_time;
    next_reg_rdata          = reg_rdata;
    if (reg_wr) begin
      if (reg_addr == ADDR_SINK7_OFF) begin
        next_sink7_off_code = reg_wdata[CODE_MSB:0];
      end else if (reg_addr == ADDR_SINK8_OFF) begin
        next_sink8_off_code = reg_wdata[CODE_MSB:0];
      end else if (reg_addr == ADDR_SINK9_OFF) begin
        next_sink9_off_code = reg_wdata[CODE_MSB:0];
      end else if (reg_addr == ADDR_FADE) begin
        next_sink_fade_out_time = reg_wdata[7:FADE_OUT_LSB];
      end
    end
    if (reg_rd) begin
      if (reg_addr == ADDR_SINK7_OFF) begin
        next_reg_rdata = {1'b0, sink7_off_code};
      end else if (reg_addr == ADDR_SINK8_OFF) begin
        next_reg_rdata = {1'b0, sink8_off_code};
      end else if (reg_addr == ADDR_SINK9_OFF) begin
        next_reg_rdata = {1'b0, sink9_off_code};
      end else if (reg_addr == ADDR_FADE) begin
        next_reg_rdata = {sink_fade_out_time, 4'h0};
      end else begin
        next_reg_rdata = 8'h00;
      end
    end
  end

  // Shared divider; all sinks step on the same tick so timing skew between them is nil
  always_comb begin
    next_tick      = 1'b0;
    next_div_count = div_count + 32'd1;
    if (div_count >= TICK_DIV - 1) begin
      next_div_count = 32'd0;
      next_tick      = 1'b1;
    end
  end

  // Flags a setup that would give a dark interval of only one clock cycle
  always_comb begin
    next_zero_warn = (sink_fade_out_time == FADE_OUT_OFF) &&
                     (sink7_off_code == CODE_ZERO_SEC || sink8_off_code == CODE_ZERO_SEC ||
                      sink9_off_code == CODE_ZERO_SEC);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sink7_off_code     <= OFF_TIME_RESET[CODE_MSB:0];
      sink8_off_code     <= OFF_TIME_RESET[CODE_MSB:0];
      sink9_off_code     <= OFF_TIME_RESET[CODE_MSB:0];
      sink_fade_out_time <= FADE_OUT_OFF;
      reg_rdata          <= 8'h00;
      div_count          <= 32'd0;
      tick               <= 1'b0;
      sink_current       <= 3'b000;
      sink_off_end       <= 3'b000;
      fade_active        <= 1'b0;
      zero_warn          <= 1'b0;
    end else begin
      sink7_off_code     <= next_sink7_off_code;
      sink8_off_code     <= next_sink8_off_code;
      sink9_off_code     <= next_sink9_off_code;
      sink_fade_out_time <= next_sink_fade_out_time;
      reg_rdata          <= next_reg_rdata;
      div_count          <= next_div_count;
      tick               <= next_tick;
      sink_current       <= conduct;
      sink_off_end       <= off_end;
      fade_active        <= sink_fade_out_time != FADE_OUT_OFF;
      zero_warn          <= next_zero_warn;
    end
  end

  assign codes = {sink9_off_code, sink8_off_code, sink7_off_code};

  for (genvar i = 0; i < 3; i++) begin : g_sink
    sink_off_channel u_chan (
      .clk      (clk),
      .rst_n    (rst_n),
      .tick     (tick),
      .enable   (sink_enable[i]),
      .off_code (codes[i*7 +: 7]),
      .on_done  (sink_on_done[i]),
      .conduct  (conduct[i]),
      .off_end  (off_end[i])
    );
  end

  AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    $past(reg_rd) && ($past(reg_addr) == ADDR_SINK7_OFF || $past(reg_addr) == ADDR_SINK8_OFF
      || $past(reg_addr) == ADDR_SINK9_OFF) |-> !reg_rdata[7])
    else $error("reserved bit read as one");
  AST_WRITE_LANDS: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == ADDR_SINK8_OFF |=> sink8_off_code == $past(reg_wdata[6:0]))
    else $error("sink8 off time write lost");
  AST_TICK_SPACING: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> !tick)
    else $error("tick pulses back to back");
  AST_FADE_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == ADDR_FADE && reg_wdata[7:4] == 4'h0 |=> ##1 !fade_active)
    else $error("fade flag set with fade disabled");
endmodule : sink_blink_off_timer

// ==== tb/sink_blink_off_timer_bench.sv ====
// Self-checking bench for the sink 7..9 off-time timers and their byte registers.
// Drives the register port and on-done pulses itself; a short tick keeps off periods brief.
`timescale 1ns/100ps
module sink_blink_off_timer_bench;
  import sink_off_pkg::*;
  localparam int TD = 20;
  logic        clk, arst_n, reg_wr, reg_rd;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
  logic [2:0]  sink_enable, sink_on_done, sink_current, sink_off_end;
  logic        fade_active, zero_warn;
  logic [31:0] rnd;
  int          mismatches, checked, cycles;

  sink_blink_off_timer #(.TICK_DIV(TD)) u_sink_blink_off_timer (
    .clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sink_enable(sink_enable),
    .sink_on_done(sink_on_done), .sink_current(sink_current), .sink_off_end(sink_off_end),
    .fade_active(fade_active), .zero_warn(zero_warn));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic conclude();
    if (mismatches == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd_chk

  // Off window allows one tick of slack since the tick phase is not aligned to off start
  task automatic blink(input int s, input logic [6:0] c);
    int   n;
    logic seen;
    n    = 0;
    seen = 1'b0;
    wr(ADDR_SINK7_OFF + 8'(s), {1'b1, c});
    @(posedge clk);
    sink_on_done[s] <= 1'b1;
    @(posedge clk);
    sink_on_done[s] <= 1'b0;
    @(posedge clk);
    #1;
    chk(8'(sink_current[s]), 8'h00);
    while (sink_current[s] !== 1'b1 && n < int'(c) * TD + 8) begin
      @(posedge clk);
      #1;
      seen |= sink_off_end[s];
      n++;
    end
    @(posedge clk);
    #1;
    seen |= sink_off_end[s];
    chk(8'(n >= (c > 7'd2 ? (int'(c) - 2) * TD : 0)), 8'h01);
    chk(8'(n <= (int'(c) - 1) * TD + 4), 8'h01);
    chk({7'h00, seen}, 8'h01);
  endtask : blink

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    {arst_n, reg_wr, reg_rd, sink_on_done} = '0;
    {reg_addr, reg_wdata} = '0;
    sink_enable = 3'b111;
    {mismatches, checked} = '0;
    rnd = 32'h11f9;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 'h1f; a <= 'h23; a++) rd_chk(8'(a), 8'h00);
    for (int a = 'h1f; a <= 'h23; a++) begin
      rnd = lfsr(rnd);
      d   = rnd[7:0] | 8'h80;
      wr(8'(a), d);
      rd_chk(8'(a), a == 'h22 ? d & 8'hf0 : a == 'h23 ? 8'h00 : d & 8'h7f);
    end
    for (int a = 'h1f; a <= 'h22; a++) wr(8'(a), 8'h00);
    wr(ADDR_SINK8_OFF, 8'h01);
    @(posedge clk);
    #1;
    chk({6'h00, fade_active, zero_warn}, 8'h01);
    wr(ADDR_FADE, 8'h3f);
    @(posedge clk);
    #1;
    chk({6'h00, fade_active, zero_warn}, 8'h02);
    // Zero code: an on-done pulse must not drop the current
    wr(ADDR_SINK8_OFF, 8'h00);
    sink_on_done <= 3'b010;
    @(posedge clk);
    sink_on_done <= 3'b000;
    d = 8'h00;
    repeat (3 * TD) begin
      @(posedge clk);
      #1;
      d |= {7'h00, ~sink_current[1]};
    end
    chk(d, 8'h00);
    blink(0, 7'd1);
    blink(1, 7'd2);
    blink(2, 7'd126);
    repeat (3) begin
      rnd = lfsr(rnd);
      blink(int'(rnd[1:0] % 3), 7'(3 + rnd[9:2] % 20));
    end
    // Hold-off code stays dark until the enable drops
    wr(ADDR_SINK9_OFF, 8'h7f);
    sink_on_done <= 3'b100;
    @(posedge clk);
    sink_on_done <= 3'b000;
    repeat (300) @(posedge clk);
    #1;
    chk({5'h00, sink_current}, 8'h03);
    @(posedge clk);
    sink_enable <= 3'b011;
    repeat (2) @(posedge clk);
    #1;
    chk({5'h00, sink_current}, 8'h03);
    @(posedge clk);
    sink_enable <= 3'b111;
    repeat (3) @(posedge clk);
    #1;
    chk({5'h00, sink_current}, 8'h07);
    conclude();
  end
endmodule : sink_blink_off_timer_bench
